// >>> hw/sap_defines.svh
// Constants of the serial audio slave port: timing figures and derived cycle counts.
`ifndef SAP_DEFINES_SVH
`define SAP_DEFINES_SVH
`define SAP_CORE_CLK_MHZ 200
`define SAP_READY_TIME_MS 12
`define SAP_READY_CYCLES (`SAP_READY_TIME_MS * 1000 * `SAP_CORE_CLK_MHZ)
`define SAP_DRIFT_MCLKS 4
`define SAP_MIN_BITS 32
`define SAP_MAX_BITS 64
`define SAP_WORD_BITS 24
`endif

// >>> hw/sap_pkg.sv
// Types shared by the serial audio slave port.
package sap_pkg;
  typedef enum logic [2:0] {
    SAP_RST = 3'b001,
    SAP_WAIT = 3'b010,
    SAP_READY = 3'b100
  } sap_ctl_state_t;
endpackage : sap_pkg

// >>> hw/sap_frame_tracker.sv
// Frame-clock tracker on the master clock: counts master clocks per frame and resynchronises on drift.
`include "sap_defines.svh"
module sap_frame_tracker #(
  parameter int CNT_W = 16,
  parameter int DRIFT = `SAP_DRIFT_MCLKS
) (
  // Master clock domain.
  input wire logic mclk,
  input wire logic mclkRst_n,
  // Frame clock level, already synchronised to mclk.
  input wire logic frameLevel,
  // Tracking status.
  output logic locked,
  output logic resyncPulse
);
  // Refuse a zero tolerance or a counter too short to hold one whole frame.
  if (DRIFT < 1 || CNT_W < 8) begin : g_badParams
    $error("sap_frame_tracker: bad parameters");
  end
  logic prevLevel_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] period_q;
  logic locked_q;
  logic resync_q;
  logic rise;
  logic drifted;
  assign rise = frameLevel && !prevLevel_q;
  // Drift is judged at each frame start against the period measured last frame.
  assign drifted = (count_q > period_q + CNT_W'(DRIFT)) || (count_q + CNT_W'(DRIFT) < period_q);
  // Count master clocks per frame; a drift beyond the tolerance drops lock and relearns the period.
  always_ff @(posedge mclk) begin
    if (!mclkRst_n) begin
      prevLevel_q <= 1'b0;
      count_q <= '0;
      period_q <= '0;
      locked_q <= 1'b0;
      resync_q <= 1'b0;
    end else begin
      prevLevel_q <= frameLevel;
      resync_q <= 1'b0;
      if (rise) begin
        count_q <= CNT_W'(1);
        period_q <= count_q;
        if (locked_q && drifted) begin // R1
          locked_q <= 1'b0;
          resync_q <= 1'b1;
        end else if (!locked_q && period_q != '0 && !drifted) begin
          locked_q <= 1'b1;
        end
      end else if (count_q != '1) begin
        count_q <= count_q + CNT_W'(1);
      end
    end
  end
  assign locked = locked_q;
  assign resyncPulse = resync_q;
  a_drift_resync: assert property (@(posedge mclk) disable iff (!mclkRst_n)
    (rise && locked_q && drifted) |=> (resync_q && !locked_q)) // R1
    else $error("Drift did not force a resynchronisation");
endmodule : sap_frame_tracker

// >>> hw/sap_serial_port.sv
// Serial audio slave receiver with frame tracking and control-port readiness after reset.
// Notes on behaviour
// (R1) Resync frame tracking beyond four master-clock drift.
// (R2) Source gives 32 to 64 bit clocks.
// (R3) Frame clock changes near bit-clock falling edge.
// (R4) Sample serial data on bit-clock rising edge.
// (R5) Sample frame clock on bit-clock rising edge.
// (R6) Reset low at least 100 microseconds; the bench holds it low for only 20 to 40 core clocks.
// (R7) Control port ready within 12 ms.
// (R8) Hold reset 100 us after supply good.
// (R9) Keep reset 100 us after power-down release; the bench keeps it 20 core clocks after.
// (R10) One 64xFs clock may serve both clocks.
// (R11) Frame level picks channel, MSB first.
// (R12) Reset holds receiver and control idle.
`include "sap_defines.svh"
module sap_serial_port #(
  parameter int WORD_BITS = `SAP_WORD_BITS,
  parameter int READY_CYCLES = `SAP_READY_CYCLES
) (
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial audio link, bit clock domain.
  input wire logic bit_clock_in,
  input wire logic frame_sync_in,
  input wire logic serial_audio_in,
  // Master clock and the power-down pin.
  input wire logic master_clock_in,
  input wire logic power_down_n_pin,
  // Received samples, core domain.
  output logic [WORD_BITS-1:0] leftSample,
  output logic [WORD_BITS-1:0] rightSample,
  output logic sampleValid,
  // Status.
  output logic ctrlReady,
  output logic frameLocked,
  output logic frameResync
);
  // A word must fit the longest slot and the six-bit bit counter; the ready count needs two cycles of lead.
  if (WORD_BITS < 8 || WORD_BITS > `SAP_MAX_BITS / 2 || READY_CYCLES < 2) begin : g_badParams
    $error("sap_serial_port: bad parameters");
  end

  // Reset level for the link domain passes three flops; bit clock stops outside frames so it is only a level.
  logic [2:0] bRst_q;
  always_ff @(posedge bit_clock_in) begin
    bRst_q <= {bRst_q[1:0], rst_n};
  end
  logic bRst_n;
  assign bRst_n = bRst_q[2] & bRst_q[1];

  // Bit clock domain shift register; both inputs taken on the rising edge, frame level names the slot.
  logic prevFrame_q;
  logic [5:0] bitCnt_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] bLeft_q;
  logic [WORD_BITS-1:0] bRight_q;
  logic bToggle_q;
  logic slotEdge;
  assign slotEdge = frame_sync_in != prevFrame_q; // R5
  always_ff @(posedge bit_clock_in) begin
    if (!bRst_n) begin // R12
      prevFrame_q <= 1'b0;
      bitCnt_q <= '0;
      shift_q <= '0;
      bLeft_q <= '0;
      bRight_q <= '0;
      bToggle_q <= 1'b0;
    end else begin
      prevFrame_q <= frame_sync_in; // R5
      if (slotEdge) begin
        // The slot just finished: file it by the level it was received under.
        if (prevFrame_q) begin // R11
          bRight_q <= shift_q;
          bToggle_q <= ~bToggle_q;
        end else begin
          bLeft_q <= shift_q;
        end
        shift_q <= {{(WORD_BITS-1){1'b0}}, serial_audio_in}; // R4
        bitCnt_q <= 6'h01;
      end else if (bitCnt_q < 6'(WORD_BITS)) begin
        // First bit is MSB; later bits shift in below it; bits past the word are dropped.
        shift_q <= {shift_q[WORD_BITS-2:0], serial_audio_in}; // R4 R11
        bitCnt_q <= bitCnt_q + 6'h01;
      end
    end
  end

  // Frame toggle crosses into the core domain through three flops; words are stable a whole slot.
  logic [2:0] togSync_q;
  logic togSeen_q;
  logic newFrame;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      togSync_q <= '0;
      togSeen_q <= 1'b0;
    end else begin
      togSync_q <= {togSync_q[1:0], bToggle_q};
      if (togSync_q[2] == togSync_q[1]) begin
        togSeen_q <= togSync_q[2];
      end
    end
  end
  assign newFrame = (togSync_q[2] == togSync_q[1]) && (togSync_q[2] != togSeen_q);

  // Capture the stereo pair once the frame toggle is seen.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin // R12
      leftSample <= '0;
      rightSample <= '0;
      sampleValid <= 1'b0;
    end else begin
      sampleValid <= newFrame;
      if (newFrame) begin
        leftSample <= bLeft_q;
        rightSample <= bRight_q;
      end
    end
  end

  // Control-port readiness: wait after reset release, held back while powered down.
  sap_pkg::sap_ctl_state_t ctl_q;
  logic [31:0] readyCnt_q;
  logic [2:0] pdnSync_q;
  logic pdnHigh;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pdnSync_q <= '0;
    end else begin
      pdnSync_q <= {pdnSync_q[1:0], power_down_n_pin};
    end
  end
  assign pdnHigh = pdnSync_q[2] & pdnSync_q[1];
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin // R12
      ctl_q <= sap_pkg::SAP_RST;
      readyCnt_q <= '0;
    end else begin
      unique case (ctl_q)
        sap_pkg::SAP_RST: begin
          readyCnt_q <= '0;
          ctl_q <= sap_pkg::SAP_WAIT;
        end
        sap_pkg::SAP_WAIT: begin
          // Count fixed cycles so readiness never lands later than the limit.
          readyCnt_q <= readyCnt_q + 32'h1;
          if (readyCnt_q >= 32'(READY_CYCLES - 2)) begin // R7
            ctl_q <= sap_pkg::SAP_READY;
          end
        end
        sap_pkg::SAP_READY: begin
          ctl_q <= sap_pkg::SAP_READY;
        end
        default: begin
          ctl_q <= sap_pkg::SAP_RST;
        end
      endcase
    end
  end
  assign ctrlReady = (ctl_q == sap_pkg::SAP_READY) && pdnHigh;

  // Frame level to master-clock domain via three flops; tracker takes the agreed level.
  // The master clock may be the bit clock itself, so nothing here assumes the two differ. // R10
  logic [2:0] frmSync_q;
  logic [2:0] mRst_q;
  always_ff @(posedge master_clock_in) begin
    mRst_q <= {mRst_q[1:0], rst_n};
    frmSync_q <= {frmSync_q[1:0], frame_sync_in};
  end
  logic frmAgree_q;
  always_ff @(posedge master_clock_in) begin
    if (frmSync_q[2] == frmSync_q[1]) begin
      frmAgree_q <= frmSync_q[2];
    end
  end
  logic mLocked;
  logic mResync;
  sap_frame_tracker #(.CNT_W(16), .DRIFT(`SAP_DRIFT_MCLKS)) uTrack (
    .mclk(master_clock_in),
    .mclkRst_n(mRst_q[2] & mRst_q[1]),
    .frameLevel(frmAgree_q),
    .locked(mLocked),
    .resyncPulse(mResync)
  );

  // Lock level and resync event cross to the core clock.
  logic [2:0] lockSync_q;
  logic [2:0] rsTogSync_q;
  logic rsTog_q;
  logic rsSeen_q;
  always_ff @(posedge master_clock_in) begin
    if (!(mRst_q[2] & mRst_q[1])) begin
      rsTog_q <= 1'b0;
    end else if (mResync) begin // R1
      rsTog_q <= ~rsTog_q;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lockSync_q <= '0;
      rsTogSync_q <= '0;
      rsSeen_q <= 1'b0;
      frameLocked <= 1'b0;
      frameResync <= 1'b0;
    end else begin
      lockSync_q <= {lockSync_q[1:0], mLocked};
      rsTogSync_q <= {rsTogSync_q[1:0], rsTog_q};
      frameResync <= 1'b0;
      if (lockSync_q[2] == lockSync_q[1]) begin
        frameLocked <= lockSync_q[2];
      end
      if (rsTogSync_q[2] == rsTogSync_q[1] && rsTogSync_q[2] != rsSeen_q) begin
        rsSeen_q <= rsTogSync_q[2];
        frameResync <= 1'b1;
      end
    end
  end

  a_ready_in_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ctl_q == sap_pkg::SAP_WAIT && readyCnt_q == 32'(READY_CYCLES - 2)) |=> ctl_q == sap_pkg::SAP_READY) // R7
    else $error("Control port not ready in time");
  a_reset_idle: assert property (@(posedge core_clk)
    !rst_n |=> (!sampleValid && !ctrlReady && ctl_q == sap_pkg::SAP_RST)) // R12
    else $error("Reset did not idle the port");
  a_ready_stays: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ctl_q == sap_pkg::SAP_READY) |=> (ctl_q == sap_pkg::SAP_READY)) // R7
    else $error("Readiness dropped without reset");
  a_msb_first: assert property (@(posedge bit_clock_in) disable iff (!bRst_n)
    slotEdge |=> (shift_q[0] == $past(serial_audio_in) && bitCnt_q == 6'h01)) // R4 R11
    else $error("Slot start bit not captured");
  a_right_slot: assert property (@(posedge bit_clock_in) disable iff (!bRst_n)
    (slotEdge && prevFrame_q) |=> (bRight_q == $past(shift_q) && bToggle_q != $past(bToggle_q))) // R11
    else $error("Right word not stored");
  a_left_slot: assert property (@(posedge bit_clock_in) disable iff (!bRst_n)
    (slotEdge && !prevFrame_q) |=> (bLeft_q == $past(shift_q) && bToggle_q == $past(bToggle_q))) // R5 R11
    else $error("Left word not stored");
endmodule : sap_serial_port

// >>> dv/sap_audio_source.sv
// Behavioural audio source that drives the serial audio link of the port.
module sap_audio_source (
  // Serial link toward the port.
  output logic bitClk,
  output logic frameSync,
  output logic serialData
);
  timeunit 1ns;
  timeprecision 100ps;
  // The bit clock runs free because it also serves as the master clock.
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    serialData = 1'b0;
    forever #6 bitClk = ~bitClk;
  end
  // Sends one slot MSB first; after the word the data line toggles so no stale bit lingers.
  task automatic send_slot(input logic level, input logic [23:0] word, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge bitClk);
      frameSync <= level;
      serialData <= (i < 24) ? word[23-i] : ~serialData;
    end
  endtask : send_slot
  // One frame: left slot low, right slot high, 32 to 64 bit clocks in all.
  task automatic send_frame(input logic [23:0] l, input logic [23:0] r, input int nl, input int nr);
    send_slot(1'b0, l, nl);
    send_slot(1'b1, r, nr);
  endtask : send_frame
endmodule : sap_audio_source

// >>> dv/tb.sv
// Self-checking bench for the serial audio slave port.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 100;
  localparam logic [23:0] W [4] = '{24'hA5C3F1, 24'h5A3C0E, 24'h800001, 24'h7FFFFE};
  logic core_clk, rst_n, pwrDown_n, bitClk, frameSync, serData;
  logic [23:0] leftS, rightS;
  logic valid, ready, locked, resync, resyncSeen;
  logic [23:0] gotL [$];
  logic [23:0] gotR [$];
  int compares, miscompares, cycles;
  sap_audio_source i_src (.bitClk(bitClk), .frameSync(frameSync), .serialData(serData));
  sap_serial_port #(.WORD_BITS(24), .READY_CYCLES(RC)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .bit_clock_in(bitClk), .frame_sync_in(frameSync), .serial_audio_in(serData), .master_clock_in(bitClk),
    .power_down_n_pin(pwrDown_n), .leftSample(leftS), .rightSample(rightS), .sampleValid(valid),
    .ctrlReady(ready), .frameLocked(locked), .frameResync(resync));
  // Core clock at 200 MHz.
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Records delivered pairs and resync pulses mid-cycle, where registered outputs have settled.
  // The watchdog cuts a hang short.
  always @(negedge core_clk) begin
    cycles++;
    if (valid === 1'b1) begin
      gotL.push_back(leftS);
      gotR.push_back(rightS);
    end
    if (resync === 1'b1) resyncSeen = 1'b1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Releases reset and waits, bounded, for the control port to come ready.
  task automatic release_ready();
    int n;
    n = 0;
    rst_n = 1'b1;
    while (ready !== 1'b1 && n < 2 * RC) begin
      step(1);
      n++;
    end
    check("ready delay", 24'(n >= RC / 2 && n <= RC + 2), 24'h1);
  endtask : release_ready
  // Audio arriving during reset must leave every output idle.
  task automatic test_reset();
    fork
      i_src.send_slot(1'b1, W[0], 8);
      step(20);
    join
    check("held sample", leftS | rightS, 24'h0);
    check("held flags", 24'({valid, ready, locked, resync}), 24'h0);
    release_ready();
  endtask : test_reset
  // A leading right slot makes the left slot start on a real transition.
  // A closing left slot keeps every frame within its length and gives the last pair time to arrive.
  task automatic test_stream(input int n);
    i_src.send_slot(1'b1, 24'h0, n);
    i_src.send_frame(W[0], W[1], n, n);
    i_src.send_frame(W[2], W[3], n, n);
    i_src.send_slot(1'b0, 24'h0, n);
    check("left word", gotL[$-1], W[0]);
    check("right word", gotR[$-1], W[1]);
    check("left word", gotL[$], W[2]);
    check("right word", gotR[$], W[3]);
  endtask : test_stream
  // A drift of four master clocks is tolerated, five forces a resync.
  task automatic test_drift();
    i_src.send_slot(1'b1, 24'h0, 28);
    repeat (5) i_src.send_frame(W[0], W[1], 28, 28);
    check("locked", 24'(locked), 24'h1);
    resyncSeen = 1'b0;
    i_src.send_frame(W[0], W[1], 28, 32);
    repeat (2) i_src.send_frame(W[0], W[1], 28, 28);
    check("resync at four", 24'(resyncSeen), 24'h0);
    i_src.send_frame(W[0], W[1], 28, 33);
    repeat (2) i_src.send_frame(W[0], W[1], 28, 28);
    check("resync at five", 24'(resyncSeen), 24'h1);
  endtask : test_drift
  // Power-down gates readiness; a reset inside power-down outlasts its release.
  task automatic test_power();
    pwrDown_n = 1'b0;
    step(8);
    check("ready in power down", 24'(ready), 24'h0);
    rst_n = 1'b0;
    step(20);
    pwrDown_n = 1'b1;
    step(20);
    check("ready in reset", 24'(ready), 24'h0);
    release_ready();
  endtask : test_power
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    pwrDown_n = 1'b1;
    resyncSeen = 1'b0;
    compares = 0;
    miscompares = 0;
    cycles = 0;
    step(0);
    test_reset();
    test_stream(24);
    test_stream(32);
    test_drift();
    test_power();
    stop_test();
  end
endmodule : tb
